/* hptsr_gang_mux.sv */
// Shared overcurrent source selector with registered output
`timescale 1ns/1ns
module hptsr_gang_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [hptsr_pkg::SEL_W-1:0] sel_i,
  input wire logic test_reset_i,
  input wire logic [hptsr_pkg::NPORT-1:0] overcurrent_pin_i,
  input wire logic spi_clk_i,
  input wire logic spi_do_i,
  input wire logic [hptsr_pkg::NPORT-1:0] port_power_control_i,
  input wire logic smbus_clock_pin_i,
  output logic shared_overcurrent_source_o
);

  logic next_src;

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (sel_i)
      hptsr_pkg::SRC_TEST_RESET: next_src = test_reset_i;
      hptsr_pkg::SRC_OVC_PIN_1: next_src = overcurrent_pin_i[0];
      hptsr_pkg::SRC_OVC_PIN_2: next_src = overcurrent_pin_i[1];
      hptsr_pkg::SRC_SPI_CLK: next_src = spi_clk_i;
      hptsr_pkg::SRC_SPI_DO: next_src = spi_do_i;
      hptsr_pkg::SRC_OVC_PIN_3: next_src = overcurrent_pin_i[2];
      hptsr_pkg::SRC_OVC_PIN_4: next_src = overcurrent_pin_i[3];
      hptsr_pkg::SRC_PWR_CTL_1: next_src = port_power_control_i[0];
      hptsr_pkg::SRC_PWR_CTL_2: next_src = port_power_control_i[1];
      hptsr_pkg::SRC_PWR_CTL_3: next_src = port_power_control_i[2];
      hptsr_pkg::SRC_PWR_CTL_4: next_src = port_power_control_i[3];
      hptsr_pkg::SRC_SMBUS_CLK: next_src = smbus_clock_pin_i;
      // Invalid codes give a quiet source rather than a random pin
      default: next_src = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_overcurrent_source_o <= 1'b0;
    end else begin
      shared_overcurrent_source_o <= next_src;
    end
  end

endmodule : hptsr_gang_mux

/* hptsr_pkg.sv */
// Package: register map, field layout and code tables of the hub port tuning/status bank
package hptsr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADR_W = 17;
  localparam int IDX_W = 15;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CHARGING_PORT_DETECTED_FLAGS = 15'h5246;
  localparam logic [IDX_W-1:0] IDX_OVERCURRENT_GANG_ENABLE = 15'h525a;
  localparam logic [IDX_W-1:0] IDX_OVERCURRENT_GANG_SOURCE_SELECT = 15'h525b;
  localparam logic [IDX_W-1:0] IDX_UPSTREAM_DRIVE_CURRENT_TUNE = 15'h60ca;
  localparam logic [IDX_W-1:0] IDX_UPSTREAM_SQUELCH_TUNE = 15'h60cc;
  localparam logic [IDX_W-1:0] IDX_UPSTREAM_SUPERSPEED_LINK_STATUS = 15'h61c0;
  localparam logic [IDX_W-1:0] IDX_PORT1_DRIVE_CURRENT_TUNE = 15'h64ca;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 15'h5300;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 15'h5301;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int NPORT = 4;
  localparam int CDP_LSB = 0;
  localparam int GANG_LSB = 1;
  localparam int SEL_W = 6;
  localparam int CODE_W = 3;
  localparam int LINK_STATE_LSB = 4;
  localparam int LINK_STATE_W = 4;
  localparam int LINK_SUB_W = 3;
  localparam int EVT_W = 6;
  localparam int EVT_CDP_LSB = 0;
  localparam int EVT_OVC = 4;
  localparam int EVT_LINK = 5;
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [CODE_W-1:0] RST_CODE = 3'h0;
  localparam logic [EVT_W-1:0] RST_EVT = 6'h00;

  // ----------------------------------------------------------------
  // Shared overcurrent source codes
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SRC_TEST_RESET = 6'h00;
  localparam logic [SEL_W-1:0] SRC_OVC_PIN_1 = 6'h01;
  localparam logic [SEL_W-1:0] SRC_OVC_PIN_2 = 6'h03;
  localparam logic [SEL_W-1:0] SRC_SPI_CLK = 6'h04;
  localparam logic [SEL_W-1:0] SRC_SPI_DO = 6'h05;
  localparam logic [SEL_W-1:0] SRC_OVC_PIN_3 = 6'h06;
  localparam logic [SEL_W-1:0] SRC_OVC_PIN_4 = 6'h07;
  localparam logic [SEL_W-1:0] SRC_PWR_CTL_1 = 6'h08;
  localparam logic [SEL_W-1:0] SRC_PWR_CTL_2 = 6'h09;
  localparam logic [SEL_W-1:0] SRC_PWR_CTL_3 = 6'h0a;
  localparam logic [SEL_W-1:0] SRC_PWR_CTL_4 = 6'h0b;
  localparam logic [SEL_W-1:0] SRC_SMBUS_CLK = 6'h0f;

  // ----------------------------------------------------------------
  // Analog tuning tables
  // ----------------------------------------------------------------
  // Drive current offset in signed percent
  function automatic logic signed [5:0] hptsr_drive_pct(input logic [CODE_W-1:0] code);
    unique case (code)
      3'h0: hptsr_drive_pct = 6'sh00;
      3'h1: hptsr_drive_pct = -6'sh05;
      3'h2: hptsr_drive_pct = 6'sh0a;
      3'h3: hptsr_drive_pct = 6'sh05;
      3'h4: hptsr_drive_pct = 6'sh14;
      3'h5: hptsr_drive_pct = 6'sh0f;
      3'h6: hptsr_drive_pct = 6'sh1e;
      3'h7: hptsr_drive_pct = 6'sh19;
    endcase
  endfunction : hptsr_drive_pct

  // Squelch trip point in tenths of a millivolt
  function automatic logic [10:0] hptsr_squelch_trip(input logic [CODE_W-1:0] code);
    unique case (code)
      3'h0: hptsr_squelch_trip = 11'h3e8;
      3'h1: hptsr_squelch_trip = 11'h36b;
      3'h2: hptsr_squelch_trip = 11'h2ee;
      3'h3: hptsr_squelch_trip = 11'h271;
      3'h4: hptsr_squelch_trip = 11'h1f4;
      3'h5: hptsr_squelch_trip = 11'h177;
      3'h6: hptsr_squelch_trip = 11'h4e2;
      3'h7: hptsr_squelch_trip = 11'h465;
    endcase
  endfunction : hptsr_squelch_trip

endpackage : hptsr_pkg

/* hptsr_regs.sv */
// Hub port tuning and status register bank on a classic Wishbone slave
//
// Contract
// - Four charging-handshake flags, ports 1 to 4 in bits 0 to 3.
// - Gang enables in bits 1 to 4 make port overcurrent follow shared source.
// - Selector bits 5:0 choose shared source from the listed pin codes.
// - Upstream drive-current code in bits 2:0 sets output current offset.
// - Port 1 drive-current code uses same table; code 110 means +30%.
// - Upstream squelch code 000 nominal 100mV, 001 to 101 lower 12.5mV steps.
// - Squelch 110 raises 25mV, 111 raises 12.5mV; bits 7:3 read-only zero.
// - Link status: state bits 7:4, substate bits 2:0, bit 3 reserved, read-only.
`timescale 1ns/1ns
module hptsr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [hptsr_pkg::ADR_W-1:0] adr_i,
  input wire logic [hptsr_pkg::DAT_W-1:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [hptsr_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // Hub core side
  input wire logic [hptsr_pkg::NPORT-1:0] cdp_handshake_done_i,
  input wire logic [hptsr_pkg::NPORT-1:0] overcurrent_pin_i,
  input wire logic test_reset_i,
  input wire logic spi_clk_i,
  input wire logic spi_do_i,
  input wire logic [hptsr_pkg::NPORT-1:0] port_power_control_i,
  input wire logic smbus_clock_pin_i,
  input wire logic [hptsr_pkg::LINK_STATE_W-1:0] link_state_i,
  input wire logic [hptsr_pkg::LINK_SUB_W-1:0] link_substate_i,
  output logic [hptsr_pkg::NPORT-1:0] port_overcurrent_o,
  output logic shared_overcurrent_source_o,
  output logic [hptsr_pkg::CODE_W-1:0] upstream_drive_current_code_o,
  output logic [hptsr_pkg::CODE_W-1:0] port1_drive_current_code_o,
  output logic [hptsr_pkg::CODE_W-1:0] upstream_squelch_threshold_code_o,
  output logic signed [5:0] upstream_drive_pct_o,
  output logic signed [5:0] port1_drive_pct_o,
  output logic [10:0] upstream_squelch_trip_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [hptsr_pkg::REG_W-1:0] cdp_flags;
  logic [hptsr_pkg::REG_W-1:0] gang_enable;
  logic [hptsr_pkg::REG_W-1:0] gang_select;
  logic [hptsr_pkg::REG_W-1:0] up_boost;
  logic [hptsr_pkg::CODE_W-1:0] up_squelch;
  logic [hptsr_pkg::REG_W-1:0] p1_boost;
  logic [hptsr_pkg::EVT_W-1:0] evt_status;
  logic [hptsr_pkg::EVT_W-1:0] evt_mask;
  logic [hptsr_pkg::LINK_STATE_W-1:0] link_state;
  logic [hptsr_pkg::LINK_SUB_W-1:0] link_substate;
  logic [hptsr_pkg::NPORT-1:0] port_ovc;
  logic ack;
  logic [hptsr_pkg::DAT_W-1:0] rdata;
  logic signed [5:0] up_pct;
  logic signed [5:0] p1_pct;
  logic [10:0] up_trip;

  logic [hptsr_pkg::REG_W-1:0] next_cdp_flags;
  logic [hptsr_pkg::REG_W-1:0] next_gang_enable;
  logic [hptsr_pkg::REG_W-1:0] next_gang_select;
  logic [hptsr_pkg::REG_W-1:0] next_up_boost;
  logic [hptsr_pkg::CODE_W-1:0] next_up_squelch;
  logic [hptsr_pkg::REG_W-1:0] next_p1_boost;
  logic [hptsr_pkg::EVT_W-1:0] next_evt_status;
  logic [hptsr_pkg::EVT_W-1:0] next_evt_mask;
  logic [hptsr_pkg::LINK_STATE_W-1:0] next_link_state;
  logic [hptsr_pkg::LINK_SUB_W-1:0] next_link_substate;
  logic [hptsr_pkg::NPORT-1:0] next_port_ovc;
  logic next_ack;
  logic [hptsr_pkg::DAT_W-1:0] next_rdata;
  logic signed [5:0] next_up_pct;
  logic signed [5:0] next_p1_pct;
  logic [10:0] next_up_trip;

  logic access;
  logic wr;
  logic rd;
  logic [hptsr_pkg::IDX_W-1:0] idx;
  logic [hptsr_pkg::REG_W-1:0] wbyte;
  logic shared_src;
  logic [hptsr_pkg::EVT_W-1:0] evt_set;
  logic [hptsr_pkg::REG_W-1:0] rd_reg;

  // ----------------------------------------------------------------
  // Shared overcurrent source
  // ----------------------------------------------------------------
  hptsr_gang_mux u_gang_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(gang_select[hptsr_pkg::SEL_W-1:0]),
    .test_reset_i(test_reset_i),
    .overcurrent_pin_i(overcurrent_pin_i),
    .spi_clk_i(spi_clk_i),
    .spi_do_i(spi_do_i),
    .port_power_control_i(port_power_control_i),
    .smbus_clock_pin_i(smbus_clock_pin_i),
    .shared_overcurrent_source_o(shared_src)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Commit happens on the edge that raises ack, so data is stable when sampled
  assign access = cyc_i && stb_i && !ack;
  assign wr = access && we_i && sel_i[0];
  assign rd = access && !we_i;
  assign idx = adr_i[hptsr_pkg::ADR_W-1:2];
  assign wbyte = dat_i[hptsr_pkg::REG_W-1:0];

  always_comb begin
    unique case (idx)
      hptsr_pkg::IDX_CHARGING_PORT_DETECTED_FLAGS: rd_reg = cdp_flags;
      hptsr_pkg::IDX_OVERCURRENT_GANG_ENABLE: rd_reg = gang_enable;
      hptsr_pkg::IDX_OVERCURRENT_GANG_SOURCE_SELECT: rd_reg = gang_select;
      hptsr_pkg::IDX_UPSTREAM_DRIVE_CURRENT_TUNE: rd_reg = up_boost;
      hptsr_pkg::IDX_UPSTREAM_SQUELCH_TUNE: rd_reg = {5'h00, up_squelch};
      hptsr_pkg::IDX_UPSTREAM_SUPERSPEED_LINK_STATUS: rd_reg = {link_state, 1'b0, link_substate};
      hptsr_pkg::IDX_PORT1_DRIVE_CURRENT_TUNE: rd_reg = p1_boost;
      hptsr_pkg::IDX_EVENT_STATUS: rd_reg = {2'h0, evt_status};
      hptsr_pkg::IDX_EVENT_MASK: rd_reg = {2'h0, evt_mask};
      // Unmapped addresses still ack and read as zero
      default: rd_reg = hptsr_pkg::RST_REG;
    endcase
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  always_comb begin
    evt_set = hptsr_pkg::RST_EVT;
    evt_set[hptsr_pkg::EVT_CDP_LSB +: hptsr_pkg::NPORT] = cdp_handshake_done_i;
    evt_set[hptsr_pkg::EVT_OVC] = shared_src && |gang_enable[hptsr_pkg::GANG_LSB +: hptsr_pkg::NPORT];
    evt_set[hptsr_pkg::EVT_LINK] = (link_state_i != link_state) || (link_substate_i != link_substate);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cdp_flags = cdp_flags;
    next_gang_enable = gang_enable;
    next_gang_select = gang_select;
    next_up_boost = up_boost;
    next_up_squelch = up_squelch;
    next_p1_boost = p1_boost;
    next_evt_mask = evt_mask;
    next_evt_status = evt_status;
    next_ack = access;
    next_rdata = '0;

    if (wr) begin
      unique case (idx)
        hptsr_pkg::IDX_CHARGING_PORT_DETECTED_FLAGS: next_cdp_flags = wbyte;
        hptsr_pkg::IDX_OVERCURRENT_GANG_ENABLE: next_gang_enable = wbyte;
        hptsr_pkg::IDX_OVERCURRENT_GANG_SOURCE_SELECT: next_gang_select = wbyte;
        hptsr_pkg::IDX_UPSTREAM_DRIVE_CURRENT_TUNE: next_up_boost = wbyte;
        hptsr_pkg::IDX_UPSTREAM_SQUELCH_TUNE: next_up_squelch = wbyte[hptsr_pkg::CODE_W-1:0];
        hptsr_pkg::IDX_PORT1_DRIVE_CURRENT_TUNE: next_p1_boost = wbyte;
        hptsr_pkg::IDX_EVENT_MASK: next_evt_mask = wbyte[hptsr_pkg::EVT_W-1:0];
        // Link status and unmapped writes are dropped
        default: next_cdp_flags = cdp_flags;
      endcase
    end

    if (rd) begin
      next_rdata = {24'h000000, rd_reg};
      if (idx == hptsr_pkg::IDX_EVENT_STATUS) begin
        next_evt_status = hptsr_pkg::RST_EVT;
      end
    end

    // Hardware set wins over software write or read-clear
    next_cdp_flags[hptsr_pkg::CDP_LSB +: hptsr_pkg::NPORT] =
      next_cdp_flags[hptsr_pkg::CDP_LSB +: hptsr_pkg::NPORT] | cdp_handshake_done_i;
    next_evt_status = next_evt_status | evt_set;

    // Ganged ports follow the shared source, others their own pin
    for (int p = 0; p < hptsr_pkg::NPORT; p++) begin
      next_port_ovc[p] = gang_enable[hptsr_pkg::GANG_LSB + p] ? shared_src : overcurrent_pin_i[p];
    end

    next_link_state = link_state_i;
    next_link_substate = link_substate_i;
    next_up_pct = hptsr_pkg::hptsr_drive_pct(up_boost[hptsr_pkg::CODE_W-1:0]);
    // Table reading takes code 110 as +30 percent
    next_p1_pct = hptsr_pkg::hptsr_drive_pct(p1_boost[hptsr_pkg::CODE_W-1:0]);
    next_up_trip = hptsr_pkg::hptsr_squelch_trip(up_squelch);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cdp_flags <= hptsr_pkg::RST_REG;
      gang_enable <= hptsr_pkg::RST_REG;
      gang_select <= hptsr_pkg::RST_REG;
      up_boost <= hptsr_pkg::RST_REG;
      up_squelch <= hptsr_pkg::RST_CODE;
      p1_boost <= hptsr_pkg::RST_REG;
      evt_status <= hptsr_pkg::RST_EVT;
      evt_mask <= hptsr_pkg::RST_EVT;
      link_state <= '0;
      link_substate <= '0;
      port_ovc <= '0;
      ack <= 1'b0;
      rdata <= '0;
      up_pct <= '0;
      p1_pct <= '0;
      up_trip <= '0;
    end else begin
      cdp_flags <= next_cdp_flags;
      gang_enable <= next_gang_enable;
      gang_select <= next_gang_select;
      up_boost <= next_up_boost;
      up_squelch <= next_up_squelch;
      p1_boost <= next_p1_boost;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      link_state <= next_link_state;
      link_substate <= next_link_substate;
      port_ovc <= next_port_ovc;
      ack <= next_ack;
      rdata <= next_rdata;
      up_pct <= next_up_pct;
      p1_pct <= next_p1_pct;
      up_trip <= next_up_trip;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ack_o = ack;
  assign dat_o = rdata;
  assign irq_o = |(evt_status & evt_mask);
  assign port_overcurrent_o = port_ovc;
  assign shared_overcurrent_source_o = shared_src;
  assign upstream_drive_current_code_o = up_boost[hptsr_pkg::CODE_W-1:0];
  assign port1_drive_current_code_o = p1_boost[hptsr_pkg::CODE_W-1:0];
  assign upstream_squelch_threshold_code_o = up_squelch;
  assign upstream_drive_pct_o = up_pct;
  assign port1_drive_pct_o = p1_pct;
  assign upstream_squelch_trip_o = up_trip;

endmodule : hptsr_regs

/* hptsr_regs_asserts.sv */
// Checker: bus handshake and output relations of the hub port tuning/status bank
`timescale 1ns/1ns
module hptsr_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [hptsr_pkg::ADR_W-1:0] adr_i,
  input wire logic [hptsr_pkg::DAT_W-1:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic [hptsr_pkg::DAT_W-1:0] dat_o,
  input wire logic ack_o,
  input wire logic [hptsr_pkg::NPORT-1:0] overcurrent_pin_i,
  input wire logic [hptsr_pkg::LINK_STATE_W-1:0] link_state_i,
  input wire logic [hptsr_pkg::LINK_SUB_W-1:0] link_substate_i,
  input wire logic [hptsr_pkg::NPORT-1:0] port_overcurrent_o,
  input wire logic shared_overcurrent_source_o,
  input wire logic [hptsr_pkg::CODE_W-1:0] upstream_drive_current_code_o,
  input wire logic [hptsr_pkg::CODE_W-1:0] port1_drive_current_code_o,
  input wire logic [hptsr_pkg::CODE_W-1:0] upstream_squelch_threshold_code_o,
  input wire logic signed [5:0] upstream_drive_pct_o,
  input wire logic signed [5:0] port1_drive_pct_o,
  input wire logic [10:0] upstream_squelch_trip_o
);
  // ----------------------------------------------------------------
  // Shadow of the gang enables and source selector
  // ----------------------------------------------------------------
  logic [3:0] gang;
  logic [5:0] src_sel;
  logic [3:0] exp_ovc;
  logic wr;
  logic [14:0] idx;
  assign idx = adr_i[16:2];
  assign wr = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
  assign exp_ovc = (gang & {4{shared_overcurrent_source_o}}) | (~gang & overcurrent_pin_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gang <= 4'h0;
      src_sel <= 6'h00;
    end else if (wr && idx == hptsr_pkg::IDX_OVERCURRENT_GANG_ENABLE) begin
      gang <= dat_i[4:1];
    end else if (wr && idx == hptsr_pkg::IDX_OVERCURRENT_GANG_SOURCE_SELECT) begin
      src_sel <= dat_i[5:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_s(logic [14:0] i);
    cyc_i && stb_i && !ack_o && !we_i && idx == i;
  endsequence
  chk_ack_follows: assert property (req_s |=> ack_o)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_link_read: assert property (rd_s(hptsr_pkg::IDX_UPSTREAM_SUPERSPEED_LINK_STATUS)
    ##0 ($stable(link_state_i) && $stable(link_substate_i))
    |=> dat_o == {24'h0, $past(link_state_i), 1'b0, $past(link_substate_i)}) else $error("link read wrong");
  chk_squelch_rsvd: assert property (rd_s(hptsr_pkg::IDX_UPSTREAM_SQUELCH_TUNE)
    |=> dat_o[7:3] == 5'h00) else $error("squelch reserved bits not zero");
  chk_up_lower: assert property (upstream_drive_current_code_o == 3'h1
    |=> upstream_drive_pct_o == 6'h3b) else $error("upstream drive code 1 not minus 5");
  chk_p1_top: assert property (port1_drive_current_code_o == 3'h6
    |=> port1_drive_pct_o == 6'h1e) else $error("port1 drive code 6 not plus 30");
  chk_sq_lowest: assert property (upstream_squelch_threshold_code_o == 3'h5
    |=> upstream_squelch_trip_o == 11'h177) else $error("squelch code 5 wrong");
  chk_sq_raise: assert property (upstream_squelch_threshold_code_o == 3'h6
    |=> upstream_squelch_trip_o == 11'h4e2) else $error("squelch code 6 wrong");
  chk_gang_follow: assert property (1'b1 |=> port_overcurrent_o == $past(exp_ovc))
    else $error("port overcurrent not following gang setting");
  chk_src_pin2: assert property (src_sel == hptsr_pkg::SRC_OVC_PIN_2
    |=> shared_overcurrent_source_o == $past(overcurrent_pin_i[1])) else $error("source code 3 wrong");
  chk_src_invalid: assert property (src_sel == 6'h02 |=> !shared_overcurrent_source_o)
    else $error("invalid source code not zero");
endmodule : hptsr_regs_chk

bind hptsr_regs hptsr_regs_chk hptsr_regs_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .overcurrent_pin_i(overcurrent_pin_i), .link_state_i(link_state_i), .link_substate_i(link_substate_i),
  .port_overcurrent_o(port_overcurrent_o), .shared_overcurrent_source_o(shared_overcurrent_source_o),
  .upstream_drive_current_code_o(upstream_drive_current_code_o),
  .port1_drive_current_code_o(port1_drive_current_code_o),
  .upstream_squelch_threshold_code_o(upstream_squelch_threshold_code_o),
  .upstream_drive_pct_o(upstream_drive_pct_o), .port1_drive_pct_o(port1_drive_pct_o),
  .upstream_squelch_trip_o(upstream_squelch_trip_o));

/* hptsr_regs_tb.sv */
// Testbench: register access, tuning tables, events and overcurrent ganging
`timescale 1ns/1ns
module hptsr_regs_tb;
  typedef struct packed {logic [14:0] idx; logic [7:0] wd; logic [7:0] rd;} hptsr_row_s;
  localparam logic [14:0] UP = hptsr_pkg::IDX_UPSTREAM_DRIVE_CURRENT_TUNE;
  localparam logic [14:0] P1 = hptsr_pkg::IDX_PORT1_DRIVE_CURRENT_TUNE;
  localparam logic [14:0] SQ = hptsr_pkg::IDX_UPSTREAM_SQUELCH_TUNE;
  localparam logic [14:0] LNK = hptsr_pkg::IDX_UPSTREAM_SUPERSPEED_LINK_STATUS;
  localparam logic [14:0] FLG = hptsr_pkg::IDX_CHARGING_PORT_DETECTED_FLAGS;
  localparam logic [14:0] GNG = hptsr_pkg::IDX_OVERCURRENT_GANG_ENABLE;
  localparam logic [14:0] SEL = hptsr_pkg::IDX_OVERCURRENT_GANG_SOURCE_SELECT;
  logic clk_i, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o, shared_overcurrent_source_o;
  logic [16:0] adr_i = 17'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h0, cdp_handshake_done_i = 4'h0, link_state_i = 4'ha, port_overcurrent_o;
  logic [2:0] link_substate_i = 3'h5, up_code, p1_code, sq_code;
  logic [11:0] src = 12'h000;
  logic signed [5:0] up_pct, p1_pct;
  logic [10:0] trip;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Write/read cases incl. squelch reserved bits, read-only link, unmapped: address, written byte, byte read back
  hptsr_row_s rows [8] = '{'{FLG, 8'ha5, 8'ha5}, '{GNG, 8'hff, 8'hff}, '{SEL, 8'hcf, 8'hcf},
    '{UP, 8'hf6, 8'hf6}, '{SQ, 8'hfd, 8'h05}, '{LNK, 8'hff, 8'ha5}, '{P1, 8'h6e, 8'h6e}, '{15'h1234, 8'hff, 8'h00}};
  logic [5:0] pct_tab [8] = '{6'h00, 6'h3b, 6'h0a, 6'h05, 6'h14, 6'h0f, 6'h1e, 6'h19};
  logic [10:0] trip_tab [8] = '{11'h3e8, 11'h36b, 11'h2ee, 11'h271, 11'h1f4, 11'h177, 11'h4e2, 11'h465};
  logic [5:0] codes [12] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0f};
  logic [5:0] bad [6] = '{6'h02, 6'h0c, 6'h0d, 6'h0e, 6'h10, 6'h3f};

  // One-hot source vector: trst, pin1, pin2, spi clk, spi do, pin3, pin4, power ctl 1-4, smbus clock
  hptsr_regs hptsr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .cdp_handshake_done_i(cdp_handshake_done_i), .overcurrent_pin_i({src[6], src[5], src[2], src[1]}),
    .test_reset_i(src[0]), .spi_clk_i(src[3]), .spi_do_i(src[4]), .port_power_control_i(src[10:7]),
    .smbus_clock_pin_i(src[11]), .link_state_i(link_state_i), .link_substate_i(link_substate_i),
    .port_overcurrent_o(port_overcurrent_o), .shared_overcurrent_source_o(shared_overcurrent_source_o),
    .upstream_drive_current_code_o(up_code), .port1_drive_current_code_o(p1_code),
    .upstream_squelch_threshold_code_o(sq_code), .upstream_drive_pct_o(up_pct), .port1_drive_pct_o(p1_pct),
    .upstream_squelch_trip_o(trip), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; no fixed latency assumed, the timeout ends a hang
  task automatic wb(input logic w, input logic [14:0] idx, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [14:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 4'hf);
    chk(rd, {24'h0, exp});
  endtask : rd_chk

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_chk(rows[i].idx, rows[i].idx == LNK ? {link_state_i, 1'b0, link_substate_i} : 8'h00);
    end
    chk({21'h0, trip}, {21'h0, trip_tab[0]});
  endtask : do_reset

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].wd, 4'h1);
      rd_chk(rows[i].idx, rows[i].rd);
    end
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, UP, 8'(c), 4'h1);
      wb(1'b1, P1, 8'(c), 4'h1);
      wb(1'b1, SQ, 8'(c), 4'h1);
      repeat (2) @(posedge clk_i);
      chk({26'h0, up_pct}, {26'h0, pct_tab[c]});
      chk({26'h0, p1_pct}, {26'h0, pct_tab[c]});
      chk({21'h0, trip}, {21'h0, trip_tab[c]});
      chk({29'h0, up_code}, 32'(c));
      chk({29'h0, p1_code}, 32'(c));
      chk({29'h0, sq_code}, 32'(c));
    end
    // Write with byte lane 0 disabled is dropped
    wb(1'b1, UP, 8'h01, 4'he);
    rd_chk(UP, 8'h07);
    link_state_i <= 4'h3;
    link_substate_i <= 3'h6;
    repeat (2) @(posedge clk_i);
    rd_chk(LNK, 8'h36);
    // Handshake event, masked then unmasked interrupt, clear on read
    wb(1'b1, FLG, 8'h00, 4'h1);
    wb(1'b1, hptsr_pkg::IDX_EVENT_MASK, 8'h00, 4'h1);
    wb(1'b0, hptsr_pkg::IDX_EVENT_STATUS, 8'h00, 4'hf);
    cdp_handshake_done_i <= 4'h4;
    @(posedge clk_i);
    cdp_handshake_done_i <= 4'h0;
    rd_chk(FLG, 8'h04);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, hptsr_pkg::IDX_EVENT_MASK, 8'h04, 4'h1);
    chk({31'h0, irq_o}, 32'h1);
    rd_chk(hptsr_pkg::IDX_EVENT_STATUS, 8'h04);
    chk({31'h0, irq_o}, 32'h0);
    rd_chk(FLG, 8'h04);
    // Handshake on the edge that takes a clearing write: the set wins
    fork
      wb(1'b1, FLG, 8'h00, 4'h1);
      begin
        @(posedge clk_i);
        cdp_handshake_done_i <= 4'h1;
        @(posedge clk_i);
        cdp_handshake_done_i <= 4'h0;
      end
    join
    rd_chk(FLG, 8'h01);
    // Every valid source code, then six of the invalid ones, all ports ganged
    wb(1'b1, GNG, 8'h1e, 4'h1);
    foreach (codes[i]) begin
      wb(1'b1, SEL, {2'b00, codes[i]}, 4'h1);
      src <= 12'h001 << i;
      repeat (3) @(posedge clk_i);
      chk({31'h0, shared_overcurrent_source_o}, 32'h1);
      chk({28'h0, port_overcurrent_o}, 32'hf);
      src <= ~(12'h001 << i);
      repeat (3) @(posedge clk_i);
      chk({31'h0, shared_overcurrent_source_o}, 32'h0);
    end
    foreach (bad[i]) begin
      wb(1'b1, SEL, {2'b00, bad[i]}, 4'h1);
      src <= 12'hfff;
      repeat (3) @(posedge clk_i);
      chk({31'h0, shared_overcurrent_source_o}, 32'h0);
    end
    // Ports 1 and 3 ganged to power control 1, ports 2 and 4 on own pins
    wb(1'b1, GNG, 8'h0a, 4'h1);
    wb(1'b1, SEL, 8'h08, 4'h1);
    src <= 12'h080;
    repeat (3) @(posedge clk_i);
    chk({28'h0, port_overcurrent_o}, 32'h5);
    src <= 12'h066;
    repeat (3) @(posedge clk_i);
    chk({28'h0, port_overcurrent_o}, 32'ha);
    do_reset();
    test_done();
  end
endmodule : hptsr_regs_tb
